/* logic/phy_ctrl_pkg.sv */
// Constants, types and timing for the basic control register of the PHY
`default_nettype none
package phy_ctrl_pkg;
    localparam logic [4:0] CTRL_OFFSET = 5'h00;
    localparam logic [4:0] PHY_ADDR = 5'h01;
    localparam int BIT_RESET = 15;
    localparam int BIT_LOOP = 14;
    localparam int BIT_SPEED = 13;
    localparam int BIT_AN_EN = 12;
    localparam int BIT_PDOWN = 11;
    localparam int BIT_ISOLATE = 10;
    localparam int BIT_RESTART = 9;
    localparam int BIT_DUPLEX = 8;
    localparam int BIT_COLTEST = 7;
    localparam logic [15:0] CTRL_RESET = 16'h3080;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [5:0] PREAMBLE_BITS = 6'h20;
    localparam logic [5:0] HDR_BITS = 6'h0d;
    localparam logic [5:0] DATA_LAST = 6'h0f;
    localparam int CLK_PERIOD_NS = 100;
    localparam int RESET_TIME_NS = 1000;
    localparam int DEAD_TIME_NS = 560;
    // Least time rounds up, longest time rounds down
    localparam logic [3:0] RESET_CYCLES =
        4'((RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0] DEAD_CYCLES = 3'(DEAD_TIME_NS / CLK_PERIOD_NS);
    typedef enum logic [2:0] {
        E_PRE = 3'b000,
        E_HDR = 3'b001,
        E_TA = 3'b010,
        E_RDAT = 3'b011,
        E_WDAT = 3'b100
    } eng_state_type;
endpackage
`default_nettype wire

/* logic/reg_access_if.sv */
// Register access path between the frame engine and the register bank
`default_nettype none
interface reg_access_if;
    logic wr_stb;
    logic [4:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic busy;
    modport engine (output wr_stb, output addr, output wdata, input rdata, input busy);
    modport bank (input wr_stb, input addr, input wdata, output rdata, output busy);
endinterface
`default_nettype wire

/* logic/mgmt_frame_engine.sv */
// Serial management frame slave: preamble, header, turnaround, data
`default_nettype none
module mgmt_frame_engine (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Register access
    reg_access_if.engine bus
);
    import phy_ctrl_pkg::*;

    typedef struct packed {
        logic mdc_s1;
        logic mdc_s2;
        logic mdc_d;
        logic dio_s1;
        logic dio_s2;
        eng_state_type state;
        logic [5:0] cnt;
        logic [15:0] sh;
        logic is_read;
        logic mine;
        logic wr_stb;
        logic [4:0] addr;
        logic [15:0] wdata;
        logic out_nxt;
        logic oe_nxt;
        logic mdio_out;
        logic mdio_oe;
    } eng_type;

    eng_type st_r;
    eng_type st_nxt;
    logic rise;
    logic fall;
    logic bit_in;
    logic [12:0] hdr;

    ////////////////////////////////////////////////////////////////////////
    // Pins are sampled by two flops; edges are found past the second one
    assign rise = st_r.mdc_s2 & ~st_r.mdc_d;
    assign fall = ~st_r.mdc_s2 & st_r.mdc_d;
    assign bit_in = st_r.dio_s2;
    assign hdr = {st_r.sh[11:0], bit_in};

    always_comb begin
        st_nxt = st_r;
        st_nxt.wr_stb = 1'b0;
        st_nxt.mdc_s1 = mdc;
        st_nxt.mdc_s2 = st_r.mdc_s1;
        st_nxt.mdc_d = st_r.mdc_s2;
        st_nxt.dio_s1 = mdio_in;
        st_nxt.dio_s2 = st_r.dio_s1;
        // Read data changes on the falling edge so the master samples it stable
        if (fall) begin
            st_nxt.mdio_out = st_r.out_nxt;
            st_nxt.mdio_oe = st_r.oe_nxt;
        end
        if (rise) begin
            case (st_r.state)
                E_PRE: begin
                    if (bit_in) begin
                        if (st_r.cnt != PREAMBLE_BITS) begin
                            st_nxt.cnt = st_r.cnt + 6'h01;
                        end
                    end else if (st_r.cnt == PREAMBLE_BITS) begin
                        st_nxt.state = E_HDR;
                        st_nxt.cnt = 6'h00;
                        st_nxt.sh = 16'h0000;
                    end else begin
                        st_nxt.cnt = 6'h00;
                    end
                end
                E_HDR: begin
                    st_nxt.sh = {st_r.sh[14:0], bit_in};
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.cnt == HDR_BITS - 6'h01) begin
                        st_nxt.cnt = 6'h00;
                        st_nxt.is_read = hdr[11:10] == OP_READ;
                        st_nxt.mine = hdr[9:5] == PHY_ADDR;
                        st_nxt.addr = hdr[4:0];
                        // Only well formed frames are served
                        if (hdr[12] && (hdr[11:10] == OP_READ || hdr[11:10] == OP_WRITE)) begin
                            st_nxt.state = E_TA;
                        end else begin
                            st_nxt.state = E_PRE;
                        end
                    end
                end
                E_TA: begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    if (st_r.is_read && st_r.mine) begin
                        st_nxt.oe_nxt = 1'b1;
                        st_nxt.out_nxt = (st_r.cnt == 6'h00) ? 1'b0 : bus.rdata[15];
                        st_nxt.sh = {bus.rdata[14:0], 1'b0};
                    end
                    if (st_r.cnt == 6'h01) begin
                        st_nxt.cnt = 6'h00;
                        st_nxt.state = st_r.is_read ? E_RDAT : E_WDAT;
                    end
                end
                E_RDAT: begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    st_nxt.out_nxt = st_r.sh[15];
                    st_nxt.sh = {st_r.sh[14:0], 1'b0};
                    if (st_r.cnt == DATA_LAST) begin
                        st_nxt.oe_nxt = 1'b0;
                        st_nxt.cnt = 6'h00;
                        st_nxt.state = E_PRE;
                    end
                end
                E_WDAT: begin
                    st_nxt.cnt = st_r.cnt + 6'h01;
                    st_nxt.sh = {st_r.sh[14:0], bit_in};
                    if (st_r.cnt == DATA_LAST) begin
                        st_nxt.wr_stb = st_r.mine;
                        st_nxt.wdata = {st_r.sh[14:0], bit_in};
                        st_nxt.cnt = 6'h00;
                        st_nxt.state = E_PRE;
                    end
                end
                default: begin
                    st_nxt.state = E_PRE;
                    st_nxt.cnt = 6'h00;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign mdio_out = st_r.mdio_out;
    assign mdio_oe = st_r.mdio_oe;
    assign bus.wr_stb = st_r.wr_stb;
    assign bus.addr = st_r.addr;
    assign bus.wdata = st_r.wdata;
endmodule // mgmt_frame_engine
`default_nettype wire

/* logic/phy_control_register.sv */
// Basic control register of the PHY and the datapath controls it steers
`default_nettype none
module phy_control_register (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Management pins
    input wire logic mdc,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Hardware configuration pins
    input wire logic loop_cfg_valid,
    input wire logic loop_cfg_value,
    input wire logic host_power_down,
    // Negotiation engine
    input wire logic an_speed_100,
    input wire logic an_full_duplex,
    output logic an_enable,
    output logic an_restart,
    // Host-side nibble interface
    input wire logic mac_tx_en,
    input wire logic [3:0] mac_txd,
    output logic mac_rx_dv,
    output logic [3:0] mac_rxd,
    // Medium side
    input wire logic line_rx_dv,
    input wire logic [3:0] line_rxd,
    output logic line_tx_en,
    output logic [3:0] line_txd,
    // Operating mode
    output logic speed_100,
    output logic full_duplex,
    output logic power_down,
    output logic isolated,
    output logic loopback_active,
    output logic core_reset
);
    import phy_ctrl_pkg::*;

    typedef struct packed {
        logic [15:0] ctrl;
        logic [3:0] rst_cnt;
        logic [2:0] dead_cnt;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic an_restart;
        logic mac_rx_dv;
        logic [3:0] mac_rxd;
        logic line_tx_en;
        logic [3:0] line_txd;
        logic speed_100;
        logic full_duplex;
        logic power_down;
        logic isolated;
        logic loopback_active;
    } bank_type;

    bank_type st_r;
    bank_type st_nxt;
    reg_access_if bus ();
    logic cfg_valid;
    logic cfg_value;
    logic host_pd;
    logic lb_eff;
    logic pd_eff;
    logic wr_ctrl;

    ////////////////////////////////////////////////////////////////////////
    // Frame engine
    mgmt_frame_engine u_engine (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .mdc(mdc),
        .mdio_in(mdio_in),
        .mdio_out(mdio_out),
        .mdio_oe(mdio_oe),
        .bus(bus)
    );

    ////////////////////////////////////////////////////////////////////////
    // Register view and effective modes
    assign cfg_valid = st_r.pin_s2[0];
    assign cfg_value = st_r.pin_s2[1];
    assign host_pd = st_r.pin_s2[2];
    assign lb_eff = cfg_valid ? cfg_value : st_r.ctrl[BIT_LOOP];
    assign pd_eff = st_r.ctrl[BIT_PDOWN] | host_pd;
    assign bus.busy = st_r.ctrl[BIT_RESET];
    // Duplex reads one while negotiating; stored bit is kept underneath
    always_comb begin
        bus.rdata = 16'h0000;
        if (bus.addr == CTRL_OFFSET) begin
            bus.rdata = st_r.ctrl;
            if (st_r.ctrl[BIT_AN_EN]) begin
                bus.rdata[BIT_DUPLEX] = 1'b1;
            end
        end
    end
    // Writes during a reset are dropped, since the register is being rebuilt
    assign wr_ctrl = bus.wr_stb && bus.addr == CTRL_OFFSET && !bus.busy;

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.pin_s1 = {host_power_down, loop_cfg_value, loop_cfg_valid};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.an_restart = 1'b0;
        // Restart bit is visible for one cycle, then clears
        st_nxt.ctrl[BIT_RESTART] = 1'b0;
        if (st_r.ctrl[BIT_RESET]) begin
            if (st_r.rst_cnt == 4'h0) begin
                st_nxt.ctrl[BIT_RESET] = 1'b0;
            end else begin
                st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
            end
        end else if (wr_ctrl) begin
            if (bus.wdata[BIT_RESET]) begin
                st_nxt.ctrl = CTRL_RESET;
                st_nxt.ctrl[BIT_RESET] = 1'b1;
                st_nxt.rst_cnt = RESET_CYCLES - 4'h1;
            end else begin
                st_nxt.ctrl[BIT_LOOP] = bus.wdata[BIT_LOOP];
                st_nxt.ctrl[BIT_SPEED] = bus.wdata[BIT_SPEED];
                st_nxt.ctrl[BIT_AN_EN] = bus.wdata[BIT_AN_EN];
                st_nxt.ctrl[BIT_PDOWN] = bus.wdata[BIT_PDOWN];
                st_nxt.ctrl[BIT_ISOLATE] = bus.wdata[BIT_ISOLATE];
                st_nxt.ctrl[BIT_COLTEST] = bus.wdata[BIT_COLTEST];
                // Reserved bits are stored as written; software keeps them zero
                st_nxt.ctrl[6:0] = bus.wdata[6:0];
                if (!bus.wdata[BIT_AN_EN]) begin
                    st_nxt.ctrl[BIT_DUPLEX] = bus.wdata[BIT_DUPLEX];
                end
                if (bus.wdata[BIT_RESTART]) begin
                    st_nxt.ctrl[BIT_RESTART] = 1'b1;
                    st_nxt.an_restart = 1'b1;
                end
            end
        end
        // Descrambler resync: receive is blanked after loopback is entered
        if (lb_eff && !st_r.loopback_active) begin
            st_nxt.dead_cnt = DEAD_CYCLES;
        end else if (st_r.dead_cnt != 3'h0) begin
            st_nxt.dead_cnt = st_r.dead_cnt - 3'h1;
        end
        st_nxt.loopback_active = lb_eff;
        st_nxt.power_down = pd_eff;
        st_nxt.isolated = st_r.ctrl[BIT_ISOLATE];
        if (st_r.ctrl[BIT_AN_EN]) begin
            st_nxt.speed_100 = an_speed_100;
            st_nxt.full_duplex = an_full_duplex;
        end else begin
            st_nxt.speed_100 = st_r.ctrl[BIT_SPEED];
            st_nxt.full_duplex = st_r.ctrl[BIT_DUPLEX];
        end
        if (lb_eff) begin
            st_nxt.full_duplex = 1'b1;
        end
        // Receive path
        st_nxt.mac_rx_dv = 1'b0;
        st_nxt.mac_rxd = 4'h0;
        if (st_r.ctrl[BIT_ISOLATE] || pd_eff || st_r.ctrl[BIT_RESET]) begin
            st_nxt.mac_rx_dv = 1'b0;
        end else if (lb_eff) begin
            if (st_r.dead_cnt == 3'h0 && st_r.loopback_active) begin
                st_nxt.mac_rx_dv = mac_tx_en;
                st_nxt.mac_rxd = mac_txd;
            end
        end else begin
            st_nxt.mac_rx_dv = line_rx_dv;
            st_nxt.mac_rxd = line_rxd;
        end
        // Transmit path
        st_nxt.line_tx_en = 1'b0;
        st_nxt.line_txd = 4'h0;
        if (!st_r.ctrl[BIT_ISOLATE] && !pd_eff && !lb_eff && !st_r.ctrl[BIT_RESET]) begin
            st_nxt.line_tx_en = mac_tx_en;
            st_nxt.line_txd = mac_txd;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
            st_r.ctrl <= CTRL_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign an_enable = st_r.ctrl[BIT_AN_EN];
    assign an_restart = st_r.an_restart;
    assign mac_rx_dv = st_r.mac_rx_dv;
    assign mac_rxd = st_r.mac_rxd;
    assign line_tx_en = st_r.line_tx_en;
    assign line_txd = st_r.line_txd;
    assign speed_100 = st_r.speed_100;
    assign full_duplex = st_r.full_duplex;
    assign power_down = st_r.power_down;
    assign isolated = st_r.isolated;
    assign loopback_active = st_r.loopback_active;
    assign core_reset = st_r.ctrl[BIT_RESET];

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    a_reset_duration: assert property (
        $rose(core_reset) |-> ##9 core_reset ##1 !core_reset)
        else $error("Reset bit did not self-clear after ten cycles");
    a_reset_defaults: assert property (
        $rose(core_reset) |-> st_r.ctrl[14:0] == CTRL_RESET[14:0])
        else $error("Control fields not at defaults during reset");
    a_reset_blocks_write: assert property (
        core_reset && bus.wr_stb |=> $stable(st_r.ctrl[14:0]))
        else $error("Write accepted while reset in progress");
    a_loop_route: assert property (
        st_r.loopback_active && lb_eff && st_r.dead_cnt == 3'h0 && !pd_eff
        && !st_r.ctrl[BIT_ISOLATE] && !core_reset |=> mac_rx_dv == $past(mac_tx_en))
        else $error("Loopback did not return transmit data");
    a_loop_isolates_line: assert property (
        lb_eff && !mac_tx_en |=> !mac_rx_dv && !line_tx_en)
        else $error("Medium reached the host during loopback");
    a_dead_time: assert property (
        $rose(loopback_active) |-> !mac_rx_dv [*5])
        else $error("Receive not blanked after loopback entry");
    a_strap_priority: assert property (
        cfg_valid |=> loopback_active == $past(cfg_value))
        else $error("Hardware loopback setting not obeyed");
    a_fixed_speed: assert property (
        !st_r.ctrl[BIT_AN_EN] |=> speed_100 == $past(st_r.ctrl[BIT_SPEED]))
        else $error("Speed bit not applied without negotiation");
    a_power_or: assert property (
        ##1 power_down == $past(st_r.ctrl[BIT_PDOWN] | host_pd))
        else $error("Power down is not the OR of both sources");
    a_isolate_both: assert property (
        st_r.ctrl[BIT_ISOLATE] |=> !mac_rx_dv && !line_tx_en)
        else $error("Isolate left a direction connected");
    a_restart_clears: assert property (
        st_r.ctrl[BIT_RESTART] |-> an_restart ##1 !st_r.ctrl[BIT_RESTART])
        else $error("Restart bit did not self-clear with a pulse");
    a_duplex_reads_one: assert property (
        st_r.ctrl[BIT_AN_EN] && bus.addr == CTRL_OFFSET |-> bus.rdata[BIT_DUPLEX])
        else $error("Duplex bit not read as one while negotiating");

    c_soft_reset: cover property ($rose(core_reset) ##10 !core_reset);
    c_loopback_data: cover property ($rose(loopback_active) ##[6:20] mac_rx_dv);
    c_ctrl_write: cover property (wr_ctrl && !bus.wdata[BIT_AN_EN]);
endmodule // phy_control_register
`default_nettype wire

/* testbench/mgmt_ctrl_model.sv */
// Behavioural management controller that issues serial frames
`default_nettype none
module mgmt_ctrl_model
    import phy_ctrl_pkg::*;
(
    // Clock
    input wire logic ref_clk,
    // Management pins
    input wire logic mdio_wire,
    output logic mdc,
    output logic mgmt_data,
    output logic mgmt_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        mdc = 1'h0;
        mgmt_data = 1'h1;
        mgmt_drive = 1'h0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Whole frames only; mdc rests low between frames, as a real controller's would
    // Half period of 5 cycles keeps clear of the 4-cycle minimum
    task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] reg_a,
        input logic [15:0] wdata, output logic [15:0] rdata);
        logic [63:0] bits;
        bits = {32'hffff_ffff, 2'h1, op, phy, reg_a, 2'h2, wdata};
        rdata = 16'h0000;
        @(posedge ref_clk);
        for (int i = 63; i >= 0; i--) begin
            mgmt_data <= bits[i];
            mgmt_drive <= (op == OP_WRITE) || (i > 17);
            repeat (5) @(posedge ref_clk);
            mdc <= 1'h1;
            if (i < 16) begin
                rdata[i] = mdio_wire;
            end
            repeat (5) @(posedge ref_clk);
            mdc <= 1'h0;
        end
        mgmt_drive <= 1'h0;
        repeat (5) @(posedge ref_clk);
    endtask
endmodule // mgmt_ctrl_model
`default_nettype wire

/* testbench/phy_control_register_tb_top.sv */
// Self-checking bench for the PHY basic control register
`default_nettype none
module phy_control_register_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import phy_ctrl_pkg::*;
    localparam int LIMIT = 40000;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic loop_cfg_valid = 1'h0, loop_cfg_value = 1'h0, host_power_down = 1'h0;
    logic an_speed_100 = 1'h0, an_full_duplex = 1'h0, mac_tx_en = 1'h0, line_rx_dv = 1'h0;
    logic [3:0] mac_txd = 4'h0, line_rxd = 4'h0;
    logic mdc, mgmt_data, mgmt_drive, mdio_wire, mdio_out, mdio_oe;
    logic an_enable, an_restart, mac_rx_dv, line_tx_en;
    logic [3:0] mac_rxd, line_txd;
    logic speed_100, full_duplex, power_down, isolated, loopback_active, core_reset;
    int seed = 80;
    int errors = 0;
    int tests_run = 0;
    int cycles = 0, restart_cnt = 0, creset_cnt = 0, oe_cnt = 0;
    always #50 ref_clk = ~ref_clk;
    // Pull-up on the data line when nobody drives it
    assign mdio_wire = mdio_oe ? mdio_out : (mgmt_drive ? mgmt_data : 1'h1);
    phy_control_register u_dut (.ref_clk(ref_clk), .reset_n(reset_n), .mdc(mdc),
        .mdio_in(mdio_wire), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .loop_cfg_valid(loop_cfg_valid), .loop_cfg_value(loop_cfg_value),
        .host_power_down(host_power_down), .an_speed_100(an_speed_100),
        .an_full_duplex(an_full_duplex), .an_enable(an_enable), .an_restart(an_restart),
        .mac_tx_en(mac_tx_en), .mac_txd(mac_txd), .mac_rx_dv(mac_rx_dv), .mac_rxd(mac_rxd),
        .line_rx_dv(line_rx_dv), .line_rxd(line_rxd), .line_tx_en(line_tx_en),
        .line_txd(line_txd), .speed_100(speed_100), .full_duplex(full_duplex),
        .power_down(power_down), .isolated(isolated), .loopback_active(loopback_active),
        .core_reset(core_reset));
    mgmt_ctrl_model u_mgmt (.ref_clk(ref_clk), .mdio_wire(mdio_wire), .mdc(mdc),
        .mgmt_data(mgmt_data), .mgmt_drive(mgmt_drive));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [4:0] phy, input logic [15:0] w);
        logic [15:0] d;
        u_mgmt.frame(OP_WRITE, phy, CTRL_OFFSET, w & 16'hff80, d);
    endtask
    task automatic rd(input logic [4:0] phy, input logic [4:0] reg_a, output logic [15:0] r);
        u_mgmt.frame(OP_READ, phy, reg_a, 16'h0000, r);
    endtask
    task automatic drive(input logic [14:0] v);
        @(posedge ref_clk);
        {loop_cfg_valid, loop_cfg_value, host_power_down, an_speed_100, an_full_duplex,
            mac_tx_en, mac_txd, line_rx_dv, line_rxd} <= v;
    endtask
    // Long enough for a soft reset launched at the frame's end to finish
    task automatic settle;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask
    function automatic logic [15:0] exp_read(input logic [15:0] w);
        exp_read = w & 16'h7d80;
        if (w[BIT_AN_EN])
            exp_read[BIT_DUPLEX] = 1'h1;
    endfunction
    task automatic check_modes(input logic [15:0] w);
        logic loop, blk;
        loop = loop_cfg_valid ? loop_cfg_value : w[BIT_LOOP];
        blk = w[BIT_PDOWN] | host_power_down | w[BIT_ISOLATE];
        chk_bit(an_enable, w[BIT_AN_EN]);
        chk_bit(loopback_active, loop);
        chk_bit(speed_100, w[BIT_AN_EN] ? an_speed_100 : w[BIT_SPEED]);
        chk_bit(full_duplex, loop | (w[BIT_AN_EN] ? an_full_duplex : w[BIT_DUPLEX]));
        chk_bit(power_down, w[BIT_PDOWN] | host_power_down);
        chk_bit(isolated, w[BIT_ISOLATE]);
        chk_bit(line_tx_en, mac_tx_en & ~loop & ~blk);
        chk_bit(mac_rx_dv, ~blk & (loop ? mac_tx_en : line_rx_dv));
        if (mac_rx_dv === 1'h1)
            chk_word({12'h000, mac_rxd}, {12'h000, loop ? mac_txd : line_rxd});
        if (line_tx_en === 1'h1)
            chk_word({12'h000, line_txd}, {12'h000, mac_txd});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        restart_cnt <= restart_cnt + int'(an_restart === 1'h1);
        creset_cnt <= creset_cnt + int'(core_reset === 1'h1);
        oe_cnt <= oe_cnt + int'(mdio_oe === 1'h1);
        if (cycles >= LIMIT) begin
            errors++;
            wrap_up;
        end
    end
    initial begin
        logic [15:0] w, r;
        logic [15:0] corner [3];
        int c0;
        corner = '{16'h4100, 16'h1180, 16'h0c80};
        repeat (12) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
        rd(PHY_ADDR, CTRL_OFFSET, r);
        chk_word(r, exp_read(CTRL_RESET));
        chk_word(r & 16'h0080, 16'h0080);
        settle;
        check_modes(CTRL_RESET);
        // Corner words first, then random words with random pin settings
        for (int k = 0; k < 14; k++) begin
            w = 16'($random(seed)) & 16'h7d80;
            if (k < 3)
                w = corner[k];
            drive(15'($random(seed)));
            wr(PHY_ADDR, w);
            settle;
            check_modes(w);
            rd(PHY_ADDR, CTRL_OFFSET, r);
            chk_word(r, exp_read(w));
        end
        drive(15'h0000);
        c0 = restart_cnt;
        wr(PHY_ADDR, 16'h1200);
        chk_word(16'(restart_cnt - c0), 16'h0001);
        rd(PHY_ADDR, CTRL_OFFSET, r);
        chk_word(r, exp_read(16'h1200));
        // Foreign address or bad opcode: no write, no drive; other register reads zero
        wr(5'h02, 16'h0000);
        c0 = oe_cnt;
        u_mgmt.frame(2'h0, PHY_ADDR, CTRL_OFFSET, 16'h0000, r);
        rd(5'h02, CTRL_OFFSET, r);
        chk_word(r, 16'hffff);
        chk_word(16'(oe_cnt - c0), 16'h0000);
        rd(PHY_ADDR, 5'h01, r);
        chk_word(r, 16'h0000);
        rd(PHY_ADDR, CTRL_OFFSET, r);
        chk_word(r, exp_read(16'h1200));
        wr(PHY_ADDR, 16'h4c00);
        c0 = creset_cnt;
        wr(PHY_ADDR, 16'h8000);
        settle;
        chk_word(16'(creset_cnt - c0), 16'(RESET_CYCLES));
        check_modes(CTRL_RESET);
        rd(PHY_ADDR, CTRL_OFFSET, r);
        chk_word(r, exp_read(CTRL_RESET));
        wr(PHY_ADDR, 16'h6d00);
        @(posedge ref_clk);
        reset_n <= 1'h0;
        repeat (3) @(posedge ref_clk);
        reset_n <= 1'h1;
        rd(PHY_ADDR, CTRL_OFFSET, r);
        chk_word(r, exp_read(CTRL_RESET));
        wrap_up;
    end
endmodule // phy_control_register_tb_top
`default_nettype wire
